/* hw/bpc_map.vh */
// Constants of the unlock-bypass program host controller.
// Notes on behaviour
// (R1) Count above 127 or other sector: error
// (R2) Count within 127, same sector: loading
// (R3) Each loaded word decrements counter once
// (R4) At count -1 confirm 29h at sector
// (R5) Count -1 with other sector: error
// (R6) Counter not negative, same page: accepted
// (R7) Latch program sector, compare later sectors
// (R8) Finished program returns to bypass idle
// (R9) Time-out hang: write F0h, back idle
// (R10) Suspend programming with 51h
// (R11) Legacy B0h accepted, host avoids it
// (R12) Suspend request settles within suspend latency
// (R13) Resume with 50h, legacy 30h avoided
// (R14) Program from erase-suspend returns there
// (R15) Erase-suspended suspend request settles likewise
// (R16) Hang reset from erase-suspend returns there
// (R17) Word entry: next data write programs
// (R18) Reads and 70h leave state unchanged
`ifndef BPC_MAP_VH
`define BPC_MAP_VH
`define BPC_OFS_CMD 5'h00
`define BPC_OFS_ADDR 5'h04
`define BPC_OFS_WDATA 5'h08
`define BPC_OFS_RDATA 5'h0C
`define BPC_OFS_STATUS 5'h10
`define BPC_OFS_IRQ_STAT 5'h14
`define BPC_OFS_IRQ_MASK 5'h18
`define BPC_OFS_CONFIG 5'h1C
`define BPC_OP_BUF_START 4'h1
`define BPC_OP_BUF_DATA 4'h2
`define BPC_OP_CONFIRM 4'h3
`define BPC_OP_WORD 4'h4
`define BPC_OP_SUSPEND 4'h5
`define BPC_OP_RESUME 4'h6
`define BPC_OP_RESET 4'h7
`define BPC_OP_STATUS 4'h8
`define BPC_OP_READ 4'h9
`define BPC_CMD_BUF_LOAD 16'h0025
`define BPC_CMD_CONFIRM 16'h0029
`define BPC_CMD_WORD 16'h00A0
`define BPC_CMD_SUSPEND 16'h0051
`define BPC_CMD_RESUME 16'h0050
`define BPC_CMD_RESET 16'h00F0
`define BPC_CMD_STATUS 16'h0070
`define BPC_STATUS_ADDR 23'h000555
`define BPC_MAX_COUNT 8'h7F
`define BPC_COUNT_DONE 8'hFF
`define BPC_SR_DONE 7
`define BPC_SR_PGM_ERR 4
`define BPC_IRQ_OP_DONE 0
`define BPC_IRQ_PROG_DONE 1
`define BPC_IRQ_PROG_FAIL 2
`define BPC_IRQ_REFUSED 3
`define BPC_IRQ_RESET 4'h0
`define BPC_CLK_NS 4
`define BPC_WE_NS 35
`define BPC_RD_NS 70
`define BPC_PSL_NS 5000
`define BPC_WE_CYC ((`BPC_WE_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_RD_CYC ((`BPC_RD_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`define BPC_PSL_CYC ((`BPC_PSL_NS + `BPC_CLK_NS - 1) / `BPC_CLK_NS)
`endif

/* hw/bpc_host_ctrl.v */
// Host controller that drives the flash unlock-bypass program command set.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bpc_map.vh"
module bpc_host_ctrl (
  input wire mclk,
  input wire srst,
  input wire [4:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  output reg [31:0] avsReaddata,
  output wire avsWaitrequest,
  output wire irq,
  output reg [22:0] flashAddr,
  output reg [15:0] flashDqOut,
  output reg flashDqOe,
  input wire [15:0] flashDqIn,
  output reg flashCeN,
  output reg flashWeN,
  output reg flashOeN
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] H_IDLE = 6'h01;
  localparam [5:0] H_LOAD = 6'h02;
  localparam [5:0] H_PROG = 6'h04;
  localparam [5:0] H_SREQ = 6'h08;
  localparam [5:0] H_SUSP = 6'h10;
  localparam [5:0] H_HANG = 6'h20;
  localparam [9:0] E_IDLE = 10'h001;
  localparam [9:0] E_W1 = 10'h002;
  localparam [9:0] E_W2 = 10'h004;
  localparam [9:0] E_POLLC = 10'h008;
  localparam [9:0] E_POLLR = 10'h010;
  localparam [9:0] E_LAT = 10'h020;
  localparam [9:0] E_RST = 10'h040;
  localparam [9:0] E_SUS = 10'h080;
  localparam [9:0] E_RD = 10'h100;
  localparam [9:0] E_STAT = 10'h200;
  localparam integer WE_CYC_I = `BPC_WE_CYC;
  localparam integer RD_CYC_I = `BPC_RD_CYC;
  localparam integer PSL_CYC_I = `BPC_PSL_CYC;
  localparam [4:0] WE_CYC = WE_CYC_I[4:0];
  localparam [4:0] RD_CYC = RD_CYC_I[4:0];
  localparam [10:0] PSL_CYC = PSL_CYC_I[10:0];

  reg respQ;
  reg [22:0] addrQ;
  reg [15:0] wdataQ;
  reg [15:0] rdataQ;
  reg [3:0] irqStatQ;
  reg [3:0] maskQ;
  reg esOriginQ;
  reg [5:0] hostQ;
  reg [9:0] engQ;
  reg [9:0] afterQ;
  reg [22:0] w1AddrQ;
  reg [15:0] w1DataQ;
  reg [22:0] w2AddrQ;
  reg [15:0] w2DataQ;
  reg needW2Q;
  reg [22:0] rdAddrQ;
  reg [7:0] latchedSectorQ;
  reg [15:0] pageQ;
  reg pageValidQ;
  reg [7:0] wordCounterQ;
  reg suspPendQ;
  reg busRunQ;
  reg [4:0] cycCntQ;
  reg [15:0] sampleQ;
  reg [7:0] lastSrQ;
  reg [10:0] latCntQ;

  // ----------------------------------------------------------------
  // Bus cycle selection
  // ----------------------------------------------------------------
  reg [22:0] curAddr;
  reg [15:0] curData;
  reg curRead;
  always @* begin
    curAddr = 23'h000000;
    curData = 16'h0000;
    curRead = 1'b0;
    case (engQ)
      E_W1: begin
        curAddr = w1AddrQ;
        curData = w1DataQ;
      end
      E_W2: begin
        curAddr = w2AddrQ;
        curData = w2DataQ;
      end
      E_POLLC, E_STAT: begin
        curAddr = `BPC_STATUS_ADDR;
        curData = `BPC_CMD_STATUS;
      end
      E_POLLR: begin
        curAddr = {latchedSectorQ, 15'h0000};
        curRead = 1'b1;
      end
      E_RST: curData = `BPC_CMD_RESET;
      E_SUS: curData = `BPC_CMD_SUSPEND; // R10 R11
      E_RD: begin
        curAddr = rdAddrQ;
        curRead = 1'b1;
      end
      default: curRead = 1'b0;
    endcase
  end

  wire busState = |(engQ & (E_W1 | E_W2 | E_POLLC | E_POLLR | E_RST | E_SUS | E_RD | E_STAT));
  wire busDone = busRunQ && (cycCntQ == 5'h00);
  wire [4:0] pulse = curRead ? RD_CYC : WE_CYC;
  wire strobeOn = busRunQ && (cycCntQ >= 5'h02) && (cycCntQ <= pulse + 5'h01);
  wire srDone = sampleQ[`BPC_SR_DONE];
  wire srErr = sampleQ[`BPC_SR_PGM_ERR];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // One wait cycle per access: the read word is built in the first cycle so that
  // it is stable from a flop when waitrequest falls.
  assign avsWaitrequest = (avsRead | avsWrite) & ~respQ;
  assign irq = |(irqStatQ & maskQ);
  wire acc = respQ & (avsRead | avsWrite);
  wire cmdWr = acc & avsWrite & (avsAddress == `BPC_OFS_CMD);
  wire [3:0] op = avsWritedata[3:0];
  wire [7:0] newSector = addrQ[22:15];
  wire sectorMatch = (newSector == latchedSectorQ); // R7
  wire engIdle = (engQ == E_IDLE);
  wire irqRd = acc & avsRead & (avsAddress == `BPC_OFS_IRQ_STAT);

  reg opOk;
  always @* begin
    opOk = 1'b0;
    case (op)
      `BPC_OP_BUF_START: opOk = engIdle && hostQ == H_IDLE && wdataQ[7:0] <= `BPC_MAX_COUNT
        && wdataQ[15:8] == 8'h00; // R1 R2
      `BPC_OP_BUF_DATA: opOk = engIdle && hostQ == H_LOAD && wordCounterQ != `BPC_COUNT_DONE
        && sectorMatch && (!pageValidQ || addrQ[22:7] == pageQ); // R5 R6
      `BPC_OP_CONFIRM: opOk = engIdle && hostQ == H_LOAD
        && wordCounterQ == `BPC_COUNT_DONE; // R4
      `BPC_OP_WORD: opOk = engIdle && hostQ == H_IDLE;
      `BPC_OP_SUSPEND: opOk = hostQ == H_PROG && !suspPendQ; // R10
      `BPC_OP_RESUME: opOk = engIdle && hostQ == H_SUSP; // R13
      `BPC_OP_RESET: opOk = engIdle;
      `BPC_OP_STATUS: opOk = engIdle && hostQ != H_LOAD; // R18
      `BPC_OP_READ: opOk = engIdle && hostQ != H_LOAD; // R18
      default: opOk = 1'b0;
    endcase
  end

  reg [3:0] irqEv;
  always @* begin
    irqEv = 4'h0;
    irqEv[`BPC_IRQ_REFUSED] = cmdWr & ~opOk;
    // The end of the suspend latency reports even though the program set a poll follow-up.
    irqEv[`BPC_IRQ_OP_DONE] = (busDone & (afterQ == E_IDLE) & (engQ != E_POLLR)
      & (engQ != E_POLLC) & ~(engQ == E_W1 & needW2Q))
      | (engQ == E_LAT & latCntQ == 11'h000);
    irqEv[`BPC_IRQ_PROG_DONE] = (engQ == E_POLLR) & busDone & srDone & ~srErr;
    irqEv[`BPC_IRQ_PROG_FAIL] = (engQ == E_POLLR) & busDone & srDone & srErr;
  end

  always @(posedge mclk) begin
    if (srst) begin
      respQ <= 1'b0;
      avsReaddata <= 32'h00000000;
      addrQ <= 23'h000000;
      wdataQ <= 16'h0000;
      maskQ <= 4'h0;
      esOriginQ <= 1'b0;
      irqStatQ <= `BPC_IRQ_RESET;
    end else begin
      respQ <= (avsRead | avsWrite) & ~respQ;
      if (~respQ) begin
        case (avsAddress)
          `BPC_OFS_ADDR: avsReaddata <= {9'h000, addrQ};
          `BPC_OFS_WDATA: avsReaddata <= {16'h0000, wdataQ};
          `BPC_OFS_RDATA: avsReaddata <= {16'h0000, rdataQ};
          `BPC_OFS_STATUS: avsReaddata <= {8'h00, lastSrQ, wordCounterQ, ~engIdle, esOriginQ, hostQ};
          `BPC_OFS_IRQ_STAT: avsReaddata <= {28'h0000000, irqStatQ};
          `BPC_OFS_IRQ_MASK: avsReaddata <= {28'h0000000, maskQ};
          `BPC_OFS_CONFIG: avsReaddata <= {31'h00000000, esOriginQ};
          default: avsReaddata <= 32'h00000000;
        endcase
      end
      if (acc & avsWrite) begin
        case (avsAddress)
          `BPC_OFS_ADDR: addrQ <= avsWritedata[22:0];
          `BPC_OFS_WDATA: wdataQ <= avsWritedata[15:0];
          `BPC_OFS_IRQ_MASK: maskQ <= avsWritedata[3:0];
          `BPC_OFS_CONFIG: begin
            if (hostQ == H_IDLE && engIdle)
              esOriginQ <= avsWritedata[0];
          end
          default: maskQ <= maskQ;
        endcase
      end
      // A new event in the cycle of the clearing read is kept.
      irqStatQ <= (irqRd ? 4'h0 : irqStatQ) | irqEv;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer and flash pins
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      hostQ <= H_IDLE;
      engQ <= E_IDLE;
      afterQ <= E_IDLE;
      w1AddrQ <= 23'h000000;
      w1DataQ <= 16'h0000;
      w2AddrQ <= 23'h000000;
      w2DataQ <= 16'h0000;
      needW2Q <= 1'b0;
      rdAddrQ <= 23'h000000;
      rdataQ <= 16'h0000;
      latchedSectorQ <= 8'h00;
      pageQ <= 16'h0000;
      pageValidQ <= 1'b0;
      wordCounterQ <= `BPC_COUNT_DONE;
      suspPendQ <= 1'b0;
      busRunQ <= 1'b0;
      cycCntQ <= 5'h00;
      sampleQ <= 16'h0000;
      lastSrQ <= 8'h00;
      latCntQ <= 11'h000;
      flashAddr <= 23'h000000;
      flashDqOut <= 16'h0000;
      flashDqOe <= 1'b0;
      flashCeN <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
    end else begin
      flashWeN <= ~(strobeOn & ~curRead);
      flashOeN <= ~(strobeOn & curRead);
      if (busRunQ && cycCntQ == 5'h01)
        sampleQ <= flashDqIn;
      if (busState && !busRunQ) begin
        busRunQ <= 1'b1;
        cycCntQ <= pulse + 5'h02;
        flashAddr <= curAddr;
        flashDqOut <= curData;
        flashDqOe <= ~curRead;
        flashCeN <= 1'b0;
      end else if (busRunQ) begin
        cycCntQ <= cycCntQ - 5'h01;
        if (busDone) begin
          busRunQ <= 1'b0;
          flashDqOe <= 1'b0;
          flashCeN <= 1'b1;
        end
      end
      if (cmdWr && opOk && op == `BPC_OP_SUSPEND)
        suspPendQ <= 1'b1; // R10
      // Suspend only marks a request, so the running sequence must keep stepping.
      if (cmdWr && opOk && op != `BPC_OP_SUSPEND) begin
        w1AddrQ <= addrQ;
        needW2Q <= 1'b0;
        afterQ <= E_IDLE;
        case (op)
          `BPC_OP_BUF_START: begin
            w1DataQ <= `BPC_CMD_BUF_LOAD;
            w2AddrQ <= addrQ;
            w2DataQ <= wdataQ;
            needW2Q <= 1'b1;
            latchedSectorQ <= newSector; // R7
            wordCounterQ <= wdataQ[7:0];
            pageValidQ <= 1'b0;
            hostQ <= H_LOAD; // R2
            engQ <= E_W1;
          end
          `BPC_OP_BUF_DATA: begin
            w1DataQ <= wdataQ;
            wordCounterQ <= wordCounterQ - 8'h01; // R3
            pageQ <= addrQ[22:7];
            pageValidQ <= 1'b1; // R6
            engQ <= E_W1;
          end
          `BPC_OP_CONFIRM: begin
            w1AddrQ <= {latchedSectorQ, 15'h0000};
            w1DataQ <= `BPC_CMD_CONFIRM; // R4
            afterQ <= E_POLLC;
            hostQ <= H_PROG;
            engQ <= E_W1;
          end
          `BPC_OP_WORD: begin
            w1DataQ <= `BPC_CMD_WORD;
            w2AddrQ <= addrQ;
            w2DataQ <= wdataQ; // R17
            needW2Q <= 1'b1;
            latchedSectorQ <= newSector;
            afterQ <= E_POLLC;
            hostQ <= H_PROG;
            engQ <= E_W1;
          end
          `BPC_OP_RESUME: begin
            w1DataQ <= `BPC_CMD_RESUME; // R13
            afterQ <= E_POLLC;
            hostQ <= H_PROG;
            engQ <= E_W1;
          end
          `BPC_OP_RESET: begin
            w1DataQ <= `BPC_CMD_RESET;
            wordCounterQ <= `BPC_COUNT_DONE;
            hostQ <= H_IDLE;
            engQ <= E_W1;
          end
          `BPC_OP_STATUS: begin
            rdAddrQ <= addrQ;
            engQ <= E_STAT; // R18
          end
          default: begin
            rdAddrQ <= addrQ;
            engQ <= E_RD;
          end
        endcase
      end else begin
        case (engQ)
          E_W1: if (busDone) engQ <= needW2Q ? E_W2 : afterQ;
          E_W2: if (busDone) engQ <= afterQ;
          E_STAT: if (busDone) engQ <= E_RD;
          E_RD: begin
            if (busDone) begin
              rdataQ <= sampleQ;
              engQ <= E_IDLE;
            end
          end
          E_POLLC: if (busDone) engQ <= E_POLLR;
          E_POLLR: begin
            if (busDone) begin
              lastSrQ <= sampleQ[7:0];
              if (srDone && srErr) begin
                hostQ <= H_HANG;
                engQ <= E_RST; // R9
              end else if (srDone) begin
                hostQ <= H_IDLE; // R8 R14
                suspPendQ <= 1'b0;
                wordCounterQ <= `BPC_COUNT_DONE;
                engQ <= E_IDLE;
              end else if (suspPendQ) begin
                engQ <= E_SUS;
              end else begin
                engQ <= E_POLLC;
              end
            end
          end
          E_SUS: begin
            if (busDone) begin
              suspPendQ <= 1'b0;
              hostQ <= H_SREQ;
              latCntQ <= PSL_CYC;
              engQ <= E_LAT;
            end
          end
          E_LAT: begin
            // Waiting the full latency avoids polling a half-suspended array.
            if (latCntQ == 11'h000) begin
              hostQ <= H_SUSP; // R12 R15
              engQ <= E_IDLE;
            end else begin
              latCntQ <= latCntQ - 11'h001;
            end
          end
          E_RST: begin
            if (busDone) begin
              hostQ <= H_IDLE; // R16
              suspPendQ <= 1'b0;
              wordCounterQ <= `BPC_COUNT_DONE;
              engQ <= E_IDLE;
            end
          end
          default: engQ <= E_IDLE;
        endcase
      end
    end
  end
endmodule // bpc_host_ctrl

/* tb/bpc_host_ctrl_monitor.sv */
// Checker of the host controller's bus handshake and flash pin sequencing.
`timescale 1ns/1ps
module bpc_monitor (
  input wire mclk,
  input wire srst,
  input wire avsRead,
  input wire avsWrite,
  input wire avsWaitrequest,
  input wire irq,
  input wire [22:0] flashAddr,
  input wire [15:0] flashDqOut,
  input wire flashDqOe,
  input wire flashCeN,
  input wire flashWeN,
  input wire flashOeN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // -----------------------------------------------------------------------
  // Sector of the last buffer start. The bench never loads the word 0025h.
  // -----------------------------------------------------------------------
  reg [7:0] sectQ = 8'h00;
  always @(posedge mclk) begin
    if (!flashWeN && flashDqOut == 16'h0025) begin
      sectQ <= flashAddr[22:15];
    end
  end
  a_wait_one: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("waitrequest held beyond one cycle");
  a_first_wait: assert property ($rose(avsRead || avsWrite) |-> avsWaitrequest)
    else $error("new request answered without its wait cycle");
  a_strobe_width: assert property ($fell(flashWeN) |-> ##1 (!flashWeN)[*8] ##1 flashWeN)
    else $error("write strobe not nine cycles");
  a_write_drives: assert property (!flashWeN |-> !flashCeN && flashDqOe && flashOeN)
    else $error("write strobe without drive");
  a_read_released: assert property (!flashOeN |-> !flashCeN && !flashDqOe && flashWeN)
    else $error("output enable while driving");
  a_status_addr: assert property ($fell(flashWeN) && flashDqOut == 16'h0070 |->
    flashAddr == 23'h000555) else $error("status command off its address");
  a_confirm_sector: assert property ($fell(flashWeN) && flashDqOut == 16'h0029 |->
    flashAddr[22:15] == sectQ) else $error("confirm at another sector");
  a_no_legacy: assert property ($fell(flashWeN) |->
    flashDqOut != 16'h00B0 && flashDqOut != 16'h0030) else $error("legacy code issued");
  a_reset_quiet: assert property ($past(srst) |->
    flashCeN && flashWeN && flashOeN && !flashDqOe && !irq) else $error("pins busy after reset");
endmodule // bpc_monitor

/* tb/bpc_flash_model.sv */
// Behavioural flash that follows the unlock-bypass program command states.
`timescale 1ns/1ps
module bpc_flash_model #(
  parameter POLLS = 20
) (
  input wire [22:0] flashAddr,
  input wire [15:0] flashDqOut,
  input wire flashCeN,
  input wire flashWeN,
  input wire flashOeN,
  input wire hangReq,
  input wire eraseOrigin,
  output wire [15:0] flashDqIn
);
  // States: 0 idle, 1 start, 2 loading, 3 programming, 4 word entry,
  // 5 suspend request, 6 suspended, 7 error, 8 erase-suspended idle.
  reg [31:0] state = 32'h0;
  reg [7:0] sect = 8'h00;
  reg [15:0] page = 16'h0000;
  reg [15:0] dq = 16'h0000;
  reg statRd = 1'b0;
  integer wc = 0;
  integer polls = 0;
  integer loaded = 0;
  wire [31:0] home = eraseOrigin ? 32'h8 : 32'h0;
  wire sameSect = flashAddr[22:15] == sect;
  // Released lines show the inverse of the last word so a stale value never passes.
  assign flashDqIn = (!flashCeN && !flashOeN) ? dq : ~dq;
  always @(negedge flashWeN) begin
    if (flashDqOut == 16'h0070) begin
      statRd = 1'b1;
    end else if (flashDqOut == 16'h00F0 && state == 32'h3) begin
      state = home;
    end else begin
      case (state)
        32'h0, 32'h8: begin
          if (flashDqOut == 16'h0025) begin
            sect = flashAddr[22:15];
            state = 32'h1;
          end else if (flashDqOut == 16'h00A0) begin
            state = 32'h4;
          end
        end
        32'h1: begin
          wc = flashDqOut;
          loaded = 0;
          state = (wc > 127 || !sameSect) ? 32'h7 : 32'h2;
        end
        32'h2: begin
          if (wc < 0) begin
            state = !sameSect ? 32'h7 : (flashDqOut == 16'h0029 ? 32'h3 : state);
          end else if (loaded == 0 || flashAddr[22:7] == page) begin
            page = flashAddr[22:7];
            wc = wc - 1;
            loaded = loaded + 1;
          end
        end
        32'h4: state = 32'h3;
        32'h3: if (flashDqOut == 16'h0051 || flashDqOut == 16'h00B0) state = 32'h5;
        32'h6: if (flashDqOut == 16'h0050 || flashDqOut == 16'h0030) state = 32'h3;
        default: ;
      endcase
    end
  end
  always @(state) begin
    if (state == 32'h5) begin
      #1000;
      if (state == 32'h5) state = 32'h6;
    end
  end
  always @(negedge flashOeN) begin
    if (statRd && state == 32'h3) begin
      polls = polls + 1;
      dq = (polls >= POLLS) ? {8'h00, 1'b1, 2'b00, hangReq, 4'h0} : 16'h0000;
      if (polls >= POLLS && !hangReq) state = home;
      if (polls >= POLLS) polls = 0;
    end else begin
      dq = statRd ? 16'h0080 : flashAddr[15:0] ^ 16'h5A5A;
    end
    statRd = 1'b0;
  end
endmodule // bpc_flash_model

/* tb/bpc_host_ctrl_tb.sv */
// Self-checking bench for the unlock-bypass program host controller.
`timescale 1ns/1ps
`include "bpc_map.vh"
module bpc_host_ctrl_tb;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg [4:0] avsAddress = 5'h00;
  reg avsRead = 1'b0;
  reg avsWrite = 1'b0;
  reg [31:0] avsWritedata = 32'h00000000;
  reg hangReq = 1'b0;
  reg eraseOrigin = 1'b0;
  reg [31:0] rd = 32'h00000000;
  wire [31:0] avsReaddata;
  wire avsWaitrequest, irq, flashDqOe, flashCeN, flashWeN, flashOeN;
  wire [22:0] flashAddr;
  wire [15:0] flashDqOut, flashDqIn;
  integer nFail = 0;
  integer nChecks = 0;
  always #2 mclk = ~mclk;
  bpc_host_ctrl u_dut (.mclk(mclk), .srst(srst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .irq(irq), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe), .flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN),
    .flashOeN(flashOeN));
  bpc_flash_model u_flash (.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashCeN(flashCeN),
    .flashWeN(flashWeN), .flashOeN(flashOeN), .hangReq(hangReq), .eraseOrigin(eraseOrigin),
    .flashDqIn(flashDqIn));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp) begin
        nFail = nFail + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task completeRun;
    begin
      if (nFail == 0 && nChecks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Waitrequest is sampled at each rising edge; the request stands until it is seen low.
  task avs(input wr, input [4:0] a, input [31:0] d);
    begin
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= wr;
      avsRead <= !wr;
      @(posedge mclk);
      while (avsWaitrequest !== 1'b0) @(posedge mclk);
      rd = avsReaddata;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task cmd(input [22:0] a, input [15:0] d, input [3:0] op);
    begin
      avs(1'b1, `BPC_OFS_ADDR, {9'h000, a});
      avs(1'b1, `BPC_OFS_WDATA, {16'h0000, d});
      avs(1'b1, `BPC_OFS_CMD, {28'h0000000, op});
    end
  endtask
  task waitBit(input [4:0] b, input v);
    integer k;
    begin
      k = 0;
      do begin
        avs(1'b0, `BPC_OFS_STATUS, 32'h00000000);
        k = k + 1;
      end while (rd[b] !== v && k < 3000);
      if (rd[b] !== v) nFail = nFail + 1;
    end
  endtask
  task tRegs;
    begin
      avs(1'b0, `BPC_OFS_STATUS, 32'h0);
      check(rd & 32'hFF, 32'h01);
      avs(1'b1, `BPC_OFS_IRQ_MASK, 32'hF);
      avs(1'b0, `BPC_OFS_IRQ_MASK, 32'h0);
      check(rd, 32'hF);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h0);
    end
  endtask
  task tBuffer;
    begin
      cmd(23'h018000, 16'h0080, `BPC_OP_BUF_START);
      waitBit(7, 1'b0);
      check({31'h0, irq}, 32'h1);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h8);
      check({31'h0, irq}, 32'h0);
      cmd(23'h018000, 16'h0001, `BPC_OP_BUF_START);
      waitBit(7, 1'b0);
      check(u_flash.state, 32'h2);
      check(rd & 32'hFFFF, 32'h0102);
      cmd(23'h020000, 16'h1111, `BPC_OP_BUF_DATA);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h9);
      cmd(23'h018000, 16'h1234, `BPC_OP_BUF_DATA);
      waitBit(7, 1'b0);
      check(rd & 32'hFFFF, 32'h0002);
      cmd(23'h018001, 16'h4321, `BPC_OP_BUF_DATA);
      waitBit(7, 1'b0);
      check(rd & 32'hFFFF, 32'hFF02);
      cmd(23'h020000, 16'h5555, `BPC_OP_BUF_DATA);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h9);
      cmd(23'h018000, 16'h0000, `BPC_OP_CONFIRM);
      waitBit(7, 1'b0);
      check(u_flash.loaded, 32'h2);
      check(u_flash.state, 32'h0);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h2);
    end
  endtask
  task tSuspend;
    begin
      cmd(23'h018010, 16'hBEEF, `BPC_OP_WORD);
      waitBit(2, 1'b1);
      cmd(23'h018010, 16'h0000, `BPC_OP_SUSPEND);
      waitBit(4, 1'b1);
      check(u_flash.state, 32'h6);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h1);
      cmd(23'h000555, 16'h0000, `BPC_OP_STATUS);
      waitBit(7, 1'b0);
      check(u_flash.state, 32'h6);
      avs(1'b0, `BPC_OFS_RDATA, 32'h0);
      check(rd, 32'h80);
      cmd(23'h018010, 16'h0000, `BPC_OP_RESUME);
      waitBit(7, 1'b0);
      check(u_flash.state, 32'h0);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h3);
    end
  endtask
  task tHang;
    begin
      hangReq <= 1'b1;
      eraseOrigin <= 1'b1;
      avs(1'b1, `BPC_OFS_CONFIG, 32'h1);
      cmd(23'h018020, 16'h0F0F, `BPC_OP_WORD);
      waitBit(7, 1'b0);
      check(rd & 32'h7F, 32'h41);
      check(u_flash.state, 32'h8);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h4);
      hangReq <= 1'b0;
      avs(1'b1, `BPC_OFS_IRQ_MASK, 32'h0);
      cmd(23'h018021, 16'h0E0E, `BPC_OP_WORD);
      waitBit(7, 1'b0);
      check(u_flash.state, 32'h8);
      check({31'h0, irq}, 32'h0);
      avs(1'b0, `BPC_OFS_IRQ_STAT, 32'h0);
      check(rd, 32'h2);
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    tRegs;
    tBuffer;
    tSuspend;
    tHang;
    completeRun;
  end
  // The scenarios need some four and a half thousand cycles; this allows about five and a half times that.
  initial begin
    #100000;
    nFail = nFail + 1;
    completeRun;
  end
endmodule // bpc_host_ctrl_tb
bind bpc_host_ctrl bpc_monitor u_mon (.mclk(mclk), .srst(srst), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest), .irq(irq), .flashAddr(flashAddr),
  .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN), .flashWeN(flashWeN),
  .flashOeN(flashOeN));
